/* File: dept_top.sv */
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ns
`include "dept_map.svh"
module dept_top (
    input  wire logic                 CLK_SYS,
    input  wire logic                 RSTN,
    input  wire logic                 CE,
    // wishbone classic slave
    input  wire logic                 CYC_I,
    input  wire logic                 STB_I,
    input  wire logic                 WE_I,
    input  wire logic [7:0]           ADR_I,
    input  wire logic [3:0]           SEL_I,
    input  wire logic [31:0]          DAT_I,
    output logic      [31:0]          DAT_O,
    output logic                      ACK_O,
    // trigger sources, one-cycle pulses per channel
    input  wire dept_pkg::dept_vec_t  TRIG_MANUAL,
    input  wire dept_pkg::dept_vec_t  TRIG_EXT,
    input  wire dept_pkg::dept_vec_t  TRIG_CHAIN,
    // hardware release of secondary-event bits
    input  wire dept_pkg::dept_vec_t  HW_SEC_CLEAR,
    // event queue offer
    output logic                      QUEUE_VALID,
    output dept_pkg::dept_chan_t      QUEUE_CHAN,
    input  wire logic                 QUEUE_READY,
    // status views
    output dept_pkg::dept_vec_t       SEC_EVENT,
    output dept_pkg::dept_vec_t       EVENT_ENABLE
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    dept_pkg::dept_vec_t    en_r;
    dept_pkg::dept_vec_t    en_nxt;
    dept_pkg::dept_vec_t    sec_r;
    dept_pkg::dept_vec_t    sec_nxt;
    dept_pkg::dept_vec_t    latch_r;
    dept_pkg::dept_vec_t    latch_nxt;
    dept_pkg::dept_qstate_t qst_r;
    dept_pkg::dept_chan_t   qchan_r;
    logic                   qvalid_r;
    logic                   ack_r;
    logic [31:0]            rdat_r;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic                   bus_req;
    logic                   bus_wr;
    logic [31:0]            wmask;
    logic [31:0]            wbits;
    logic [31:0]            rdat_nxt;
    dept_pkg::dept_vec_t    en_set;
    dept_pkg::dept_vec_t    en_clr;
    dept_pkg::dept_vec_t    sec_sw_clr;

    // a request is served once, in the cycle before ack rises
    assign bus_req = CYC_I & STB_I & ~ack_r;
    assign bus_wr  = bus_req & WE_I;
    assign wmask   = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    assign wbits   = DAT_I & wmask;

    always_comb begin
        en_set     = '0;
        en_clr     = '0;
        sec_sw_clr = '0;
        if (bus_wr) begin
            case (ADR_I)
                `DEPT_OFS_EN_SET_LO: begin
                    en_set[31:0] = wbits;
                end
                `DEPT_OFS_EN_SET_HI: begin
                    en_set[63:32] = wbits;
                end
                `DEPT_OFS_EN_CLR_LO: begin
                    en_clr[31:0] = wbits;
                end
                `DEPT_OFS_EN_CLR_HI: begin
                    en_clr[63:32] = wbits;
                end
                `DEPT_OFS_SEC_CLR_LO: begin
                    sec_sw_clr[31:0] = wbits;
                end
                `DEPT_OFS_SEC_CLR_HI: begin
                    sec_sw_clr[63:32] = wbits;
                end
                default: begin
                    en_set = '0;
                end
            endcase
        end
    end

    // write-only words read zero; unmapped reads zero too
    always_comb begin
        case (ADR_I)
            `DEPT_OFS_EN_LO: begin
                rdat_nxt = en_r[31:0];
            end
            `DEPT_OFS_EN_HI: begin
                rdat_nxt = en_r[63:32];
            end
            `DEPT_OFS_SEC_LO: begin
                rdat_nxt = sec_r[31:0];
            end
            `DEPT_OFS_SEC_HI: begin
                rdat_nxt = sec_r[63:32];
            end
            `DEPT_OFS_LATCH_LO: begin
                rdat_nxt = latch_r[31:0];
            end
            `DEPT_OFS_LATCH_HI: begin
                rdat_nxt = latch_r[63:32];
            end
            default: begin
                rdat_nxt = `DEPT_RST_WORD;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ack_r <= 1'b0;
        end else if (CE) begin
            ack_r <= bus_req;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rdat_r <= `DEPT_RST_WORD;
        end else if (CE) begin
            if (bus_req && !WE_I) begin
                rdat_r <= rdat_nxt;
            end else begin
                rdat_r <= `DEPT_RST_WORD;
            end
        end
    end

    // ----------------------------------------
    // arbitration
    // ----------------------------------------
    dept_arb_if arb ();

    logic                   q_accept;
    dept_pkg::dept_vec_t    acc_vec;
    dept_pkg::dept_vec_t    trig_vec;

    assign arb.req  = latch_r & ~sec_r;
    assign q_accept = (qst_r == dept_pkg::DEPT_Q_OFFER) & QUEUE_READY;
    assign acc_vec  = q_accept ? (64'h1 << qchan_r) : '0;
    // external events need the enable; manual and chained do not
    assign trig_vec = TRIG_MANUAL | (TRIG_EXT & en_r) | TRIG_CHAIN;

    dept_arbiter u_arb (
        .arb (arb)
    );

    // one offer in flight keeps the arbiter from picking it twice
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            qst_r    <= dept_pkg::DEPT_Q_IDLE;
            qchan_r  <= '0;
            qvalid_r <= 1'b0;
        end else if (CE) begin
            case (qst_r)
                dept_pkg::DEPT_Q_IDLE: begin
                    if (arb.gnt_valid) begin
                        qst_r    <= dept_pkg::DEPT_Q_OFFER;
                        qchan_r  <= arb.gnt_chan;
                        qvalid_r <= 1'b1;
                    end
                end
                dept_pkg::DEPT_Q_OFFER: begin
                    if (QUEUE_READY) begin
                        qst_r    <= dept_pkg::DEPT_Q_IDLE;
                        qvalid_r <= 1'b0;
                    end
                end
                default: begin
                    qst_r    <= dept_pkg::DEPT_Q_IDLE;
                    qvalid_r <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // per-channel bits
    // ----------------------------------------
    for (genvar c = 0; c < `DEPT_NCH; c++) begin : g_ch
        // enable changes only by set or clear
        assign en_nxt[c] = (en_r[c] & ~en_clr[c]) | en_set[c];
        // a trigger in the accept cycle stays latched as a new event
        assign latch_nxt[c] = (latch_r[c] & ~acc_vec[c]) | trig_vec[c];
        // set on accept; hw or sw clear; set wins
        assign sec_nxt[c] = (sec_r[c] & ~(HW_SEC_CLEAR[c] | sec_sw_clr[c])) | acc_vec[c];
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            en_r <= `DEPT_RST_VEC;
        end else if (CE) begin
            en_r <= en_nxt;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            latch_r <= `DEPT_RST_VEC;
        end else if (CE) begin
            latch_r <= latch_nxt;
        end
    end

    // zero at reset, set on accept, cleared by hw release or bus write; 1 = held in queue
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            sec_r <= `DEPT_RST_VEC;
        end else if (CE) begin
            sec_r <= sec_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign DAT_O        = rdat_r;
    assign ACK_O        = ack_r;
    assign QUEUE_VALID  = qvalid_r;
    assign QUEUE_CHAN   = qchan_r;
    assign SEC_EVENT    = sec_r;
    assign EVENT_ENABLE = en_r;

endmodule

/* File: dept_map.svh */
// Behaviour
// - A one written to a bit of event_enable_set_high sets enable bit for events 32-63, a zero leaves it.
// - Bit n of event_enable_high holds the enable of event n plus 32.
// - A manual, external or chained request for a channel 0-63 accepted into the queue sets its secondary-event bit.
// - While a channel's secondary-event bit is set, no further event of that channel is prioritized or queued.
// - The secondary-event bit is cleared by hardware or by a software clear write before new events are evaluated.
// - A secondary-event bit of 0 means not held in the queue, 1 means held and not prioritized.
// - Secondary-event bits are read beside the event-latch bits, low register channels 0-31, high 32-63.
// - Both secondary-event registers are read-only and read zero after reset.
// - A one written to a secondary-event clear bit clears that secondary-event bit, a zero does nothing.
// - secondary_event_clear_low is write-only, bit n for channel n of 0-31, zero after reset.
// - Event-enable bits change only through the set and clear registers, never by direct write.
`ifndef DEPT_MAP_SVH
`define DEPT_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DEPT_OFS_EN_LO      8'h00
`define DEPT_OFS_EN_HI      8'h04
`define DEPT_OFS_EN_SET_LO  8'h08
`define DEPT_OFS_EN_SET_HI  8'h0c
`define DEPT_OFS_EN_CLR_LO  8'h10
`define DEPT_OFS_EN_CLR_HI  8'h14
`define DEPT_OFS_SEC_LO     8'h18
`define DEPT_OFS_SEC_HI     8'h1c
`define DEPT_OFS_SEC_CLR_LO 8'h20
`define DEPT_OFS_SEC_CLR_HI 8'h24
`define DEPT_OFS_LATCH_LO   8'h28
`define DEPT_OFS_LATCH_HI   8'h2c

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define DEPT_NCH            64
`define DEPT_CHW            6
`define DEPT_RST_WORD       32'h0000_0000
`define DEPT_RST_VEC        64'h0000_0000_0000_0000

`endif

/* File: dept_pkg.sv */
package dept_pkg;
    typedef logic [63:0] dept_vec_t;
    typedef logic [5:0]  dept_chan_t;
    typedef enum logic [0:0] {
        DEPT_Q_IDLE,
        DEPT_Q_OFFER
    } dept_qstate_t;
endpackage

/* File: dept_arb_if.sv */
`timescale 1ns/1ns
// request vector in, lowest-numbered winner out
interface dept_arb_if;
    dept_pkg::dept_vec_t  req;
    logic                 gnt_valid;
    dept_pkg::dept_chan_t gnt_chan;

    modport requester (
        output req,
        input  gnt_valid,
        input  gnt_chan
    );
    modport arbiter (
        input  req,
        output gnt_valid,
        output gnt_chan
    );
endinterface

/* File: dept_arbiter.sv */
`timescale 1ns/1ns
`include "dept_map.svh"
module dept_arbiter (
    dept_arb_if.arbiter arb
);
    // ----------------------------------------
    // fixed priority, channel 0 highest
    // ----------------------------------------
    always_comb begin
        arb.gnt_valid = 1'b0;
        arb.gnt_chan  = '0;
        for (int i = `DEPT_NCH - 1; i >= 0; i--) begin
            if (arb.req[i]) begin
                arb.gnt_valid = 1'b1;
                arb.gnt_chan  = 6'(i);
            end
        end
    end
endmodule

/* File: dept_top_sva.sv */
`timescale 1ns/1ns
module dept_top_sva (
    input wire logic                 CLK_SYS,
    input wire logic                 RSTN,
    input wire logic                 CE,
    input wire logic                 WE_I,
    input wire logic                 ACK_O,
    input wire dept_pkg::dept_vec_t  HW_SEC_CLEAR,
    input wire logic                 QUEUE_VALID,
    input wire dept_pkg::dept_chan_t QUEUE_CHAN,
    input wire logic                 QUEUE_READY,
    input wire dept_pkg::dept_vec_t  SEC_EVENT,
    input wire dept_pkg::dept_vec_t  EVENT_ENABLE
);
    // ----
    // checks
    // ----
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);
    property p_ack; CE && ACK_O |=> !ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("ack held");
    property p_set; CE && QUEUE_VALID && QUEUE_READY |=> SEC_EVENT[$past(QUEUE_CHAN)]; endproperty
    a_set: assert property (p_set) else $error("no set");
    property p_held; QUEUE_VALID |-> !SEC_EVENT[QUEUE_CHAN]; endproperty
    a_held: assert property (p_held) else $error("held offer");
    property p_hold; QUEUE_VALID && !QUEUE_READY |=> QUEUE_VALID && $stable(QUEUE_CHAN); endproperty
    a_hold: assert property (p_hold) else $error("offer lost");
    property p_rst; $rose(RSTN) |-> SEC_EVENT == 64'h0 && EVENT_ENABLE == 64'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_en; EVENT_ENABLE != $past(EVENT_ENABLE) |-> ACK_O && WE_I; endproperty
    a_en: assert property (p_en) else $error("enable moved");
    property p_rise; (SEC_EVENT & ~$past(SEC_EVENT)) != 64'h0 |-> $past(QUEUE_VALID && QUEUE_READY);
    endproperty
    a_rise: assert property (p_rise) else $error("stray set");
    property p_fall; ($past(SEC_EVENT) & ~SEC_EVENT) != 64'h0
        |-> (ACK_O && WE_I) || $past(HW_SEC_CLEAR) != 64'h0; endproperty
    a_fall: assert property (p_fall) else $error("stray clear");
    c_acc: cover property (QUEUE_VALID && QUEUE_READY);
    c_stall: cover property (QUEUE_VALID && !QUEUE_READY);
    c_wr: cover property (ACK_O && WE_I);
endmodule

/* File: dept_queue_model.sv */
`timescale 1ns/1ns
module dept_queue_model (
    input  wire logic                 clk,
    input  wire logic                 slow,
    input  wire logic                 hw_rel,
    input  wire logic                 valid,
    input  wire dept_pkg::dept_chan_t chan,
    output logic                      ready,
    output dept_pkg::dept_vec_t       sec_clr
);
    logic ph_r = 1'b0;
    // ----
    // queue side
    // ----
    // slow mode stalls every other cycle
    assign ready = !slow || ph_r;
    always_ff @(posedge clk) begin
        ph_r <= !ph_r;
        sec_clr <= {63'h0, hw_rel && valid && ready} << chan;
    end
endmodule

/* File: dept_top_tb.sv */
`timescale 1ns/1ns
module dept_top_tb;
    logic                 clk = 1'b0, rstn = 1'b0, cyc = 1'b0, we = 1'b0;
    logic                 slow = 1'b0, hw_rel = 1'b0, ack, qv, rdy;
    logic [7:0]           adr = 8'h00;
    logic [31:0]          wd = 32'h0, rd, q;
    dept_pkg::dept_chan_t qc;
    dept_pkg::dept_vec_t  man = 64'h0, ext = 64'h0, chn = 64'h0, sec, en, hwc;
    int                   err_count = 0;
    int                   samples_checked = 0;
    dept_top i_dut (.CLK_SYS(clk), .RSTN(rstn), .CE(1'b1), .CYC_I(cyc), .STB_I(cyc),
        .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(wd), .DAT_O(rd), .ACK_O(ack),
        .TRIG_MANUAL(man), .TRIG_EXT(ext), .TRIG_CHAIN(chn), .HW_SEC_CLEAR(hwc),
        .QUEUE_VALID(qv), .QUEUE_CHAN(qc), .QUEUE_READY(rdy), .SEC_EVENT(sec),
        .EVENT_ENABLE(en));
    dept_queue_model i_q (.clk(clk), .slow(slow), .hw_rel(hw_rel), .valid(qv),
        .chan(qc), .ready(rdy), .sec_clr(hwc));
    // ----
    // helpers
    // ----
    initial forever #20 clk = ~clk;
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("unexpected at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
        q = rd;
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            err_count++;
            complete_run();
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk({32'h0, q}, {32'h0, e});
    endtask
    task automatic wsec(input int ch, input logic v);
        int n = 0;
        while (sec[ch] !== v && ++n < 40) @(posedge clk);
        chk(n < 40, 1'b1);
        if (n >= 40) begin
            complete_run();
        end
    endtask
    task automatic wq(input logic [5:0] ch);
        int n = 0;
        while (qv !== 1'b1 && ++n < 40) @(posedge clk);
        chk({58'h0, qc}, {58'h0, ch});
        if (n >= 40) begin
            err_count++;
            complete_run();
        end
    endtask
    task automatic pulse(input int ch);
        man[ch] <= 1'b1;
        @(posedge clk);
        man <= 64'h0;
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        wb(1'b1, 8'h18, 32'hffff_ffff);
        rc(8'h18, 32'h0);
        rc(8'h1c, 32'h0);
        rc(8'h20, 32'h0);
        rc(8'h30, 32'h0);
        $display("test registers done");
        wb(1'b1, 8'h0c, 32'h8000_0001);
        wb(1'b1, 8'h0c, 32'h0);
        wb(1'b1, 8'h04, 32'hffff_ffff);
        rc(8'h04, 32'h8000_0001);
        chk(en, 64'h8000_0001_0000_0000);
        wb(1'b1, 8'h14, 32'h8000_0000);
        wb(1'b1, 8'h08, 32'h0000_0001);
        rc(8'h04, 32'h0000_0001);
        rc(8'h00, 32'h0000_0001);
        $display("test enable done");
        chn[40] <= 1'b1;
        pulse(5);
        chn <= 64'h0;
        wq(6'd5);
        wsec(40, 1'b1);
        rc(8'h18, 32'h0000_0020);
        rc(8'h1c, 32'h0000_0100);
        pulse(5);
        repeat (6) @(posedge clk);
        chk(qv, 1'b0);
        rc(8'h28, 32'h0000_0020);
        wb(1'b1, 8'h20, 32'h0);
        chk(sec[5], 1'b1);
        wb(1'b1, 8'h20, 32'h0000_0020);
        wsec(5, 1'b1);
        wb(1'b1, 8'h20, 32'h0000_0020);
        wb(1'b1, 8'h24, 32'h0000_0100);
        rc(8'h18, 32'h0);
        rc(8'h1c, 32'h0);
        $display("test queue done");
        slow <= 1'b1;
        ext[32] <= 1'b1;
        ext[34] <= 1'b1;
        @(posedge clk);
        ext <= 64'h0;
        wsec(32, 1'b1);
        repeat (6) @(posedge clk);
        chk(sec[34], 1'b0);
        hw_rel <= 1'b1;
        pulse(7);
        repeat (8) @(posedge clk);
        chk(sec[7], 1'b0);
        rc(8'h1c, 32'h0000_0001);
        $display("test trigger done");
        complete_run();
    end
endmodule
bind dept_top dept_top_sva i_sva (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE), .WE_I(WE_I),
    .ACK_O(ACK_O), .HW_SEC_CLEAR(HW_SEC_CLEAR), .QUEUE_VALID(QUEUE_VALID),
    .QUEUE_CHAN(QUEUE_CHAN), .QUEUE_READY(QUEUE_READY), .SEC_EVENT(SEC_EVENT),
    .EVENT_ENABLE(EVENT_ENABLE));
